// file: design/fphp_params.svh
`ifndef FPHP_PARAMS_SVH
`define FPHP_PARAMS_SVH

`define FPHP_DATA_W        8
`define FPHP_ADDR_W        5
`define FPHP_NREGS         32
`define FPHP_CLK_PERIOD_PS 4000
`define FPHP_RESET_MIN_NS  1000
`define FPHP_RESET_CYCLES  ((`FPHP_RESET_MIN_NS * 1000 + `FPHP_CLK_PERIOD_PS - 1) / `FPHP_CLK_PERIOD_PS)
`define FPHP_REG_RESET     8'h00
`define FPHP_STROBE_HOLD   4

`endif

// file: design/fphp_pkg.sv
`include "fphp_params.svh"

package fphp_pkg;
  typedef logic [`FPHP_DATA_W-1:0] fphp_data_t;
  typedef logic [`FPHP_ADDR_W-1:0] fphp_addr_t;
  typedef enum logic [1:0]
  {
    FPHP_IDLE  = 2'b00,
    FPHP_SETUP = 2'b01,
    FPHP_PULSE = 2'b10,
    FPHP_DONE  = 2'b11
  } fphp_hstate_t;
endpackage

// file: design/fphp_bus_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fphp_bus_if;
  import fphp_pkg::*;
  logic       bus_style_select;
  logic       data_strobe_n;
  logic       dir_store_n;
  logic       select_n;
  logic       reset_n;
  fphp_addr_t register_select_lines;
  fphp_data_t host_data_o;
  logic       host_data_oe;
  fphp_data_t dev_data_o;
  logic       dev_data_oe;
  logic       irq_pull_oe;
  fphp_data_t data_bus;
  logic       irq_n;

  // Wire levels resolved from the enables
  assign data_bus = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : '1);
  assign irq_n    = irq_pull_oe ? 1'b0 : 1'b1;

  modport device
  (
    input  bus_style_select, data_strobe_n, dir_store_n, select_n, reset_n,
    input  register_select_lines, data_bus,
    output dev_data_o, dev_data_oe, irq_pull_oe
  );
  modport host
  (
    output bus_style_select, data_strobe_n, dir_store_n, select_n, reset_n,
    output register_select_lines, host_data_o, host_data_oe,
    input  data_bus, irq_n
  );
endinterface

`default_nettype wire

// file: design/fphp_device.sv
// Function
// - Style pin picks strobe pair or direction
// - Direction style: shared strobe is data strobe
// - Pair style: shared strobe is read strobe
// - Direction style: direction pin high reads, low writes
// - Pair style: direction pin is store strobe
// - Respond only while select low, else float
// - Eight-bit bidirectional data, bit0 LSB
// - Five-bit register select, bit0 LSB
// - Open-drain interrupt low while pending, except while in reset
// - Host holds reset low at least 1000 ns
`timescale 1ns/1ps
`default_nettype none
`include "fphp_params.svh"

module fphp_device #(
  parameter int NREGS = `FPHP_NREGS
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  fphp_bus_if.device                bus,
  input  wire logic [NREGS-1:0]     irq_src,
  output logic                      core_reset,
  output fphp_pkg::fphp_data_t      wr_data,
  output fphp_pkg::fphp_addr_t      wr_addr,
  output logic                      wr_pulse
);
  import fphp_pkg::*;

  // Shared strobe and direction pins change meaning with the bus style
  function automatic logic read_decode
  (
    input logic pair,
    input logic strobe_n,
    input logic dir_n
  );
    logic hit;
    if (pair)
    begin
      hit = ~strobe_n;
    end
    else
    begin
      hit = ~strobe_n & dir_n;
    end
    return hit;
  endfunction

  // Store qualification per bus style
  function automatic logic store_decode
  (
    input logic pair,
    input logic strobe_n,
    input logic dir_n
  );
    logic hit;
    if (pair)
    begin
      hit = ~dir_n;
    end
    else
    begin
      hit = ~strobe_n & ~dir_n;
    end
    return hit;
  endfunction

  // Selects beyond the implemented registers read zero, ignore writes
  function automatic logic addr_in_range
  (
    input fphp_addr_t addr
  );
    return int'(addr) < NREGS;
  endfunction

  // Register file and port state
  fphp_data_t       regs_q [NREGS];
  fphp_data_t       rd_q;
  fphp_data_t       rd_sel;
  fphp_data_t       data_q;
  fphp_addr_t       addr_q;
  logic             store_q;
  logic             store_d;
  logic             wr_pulse_q;
  wire fphp_data_t  bus_in;
  wire [NREGS-1:0]  wr_hit;

  // Host reset pin also holds the port in reset
  wire style_pair = bus.bus_style_select;
  wire selected   = ~bus.select_n;
  wire in_reset   = rst | ~bus.reset_n;
  wire read_qual  = read_decode(style_pair, bus.data_strobe_n, bus.dir_store_n);
  wire store_qual = store_decode(style_pair, bus.data_strobe_n, bus.dir_store_n);
  wire store_end  = store_q & ~store_d;
  wire rd_addr_ok = addr_in_range(bus.register_select_lines);
  wire wr_addr_ok = addr_in_range(addr_q);
  wire drive_read = ~in_reset & selected & read_qual;
  wire irq_any    = ~in_reset & (|irq_src);

  assign store_d = selected & store_qual;
  assign rd_sel  = rd_addr_ok ? regs_q[bus.register_select_lines] : 8'h00;

  // Data lines taken one by one, line zero as the low bit
  genvar b;
  generate
    for (b = 0; b < `FPHP_DATA_W; b++)
    begin : g_bit
      assign bus_in[b] = bus.data_bus[b];
    end
  endgenerate

  // Store seen last cycle; its fall marks the commit
  always_ff @(posedge clk)
  begin
    if (in_reset)
    begin
      store_q <= 1'b0;
    end
    else
    begin
      store_q <= store_d;
    end
  end

  // Commit strobe for the core, one cycle
  always_ff @(posedge clk)
  begin
    if (in_reset)
    begin
      wr_pulse_q <= 1'b0;
    end
    else
    begin
      wr_pulse_q <= store_end;
    end
  end

  // Last stored address and byte held for the commit
  always_ff @(posedge clk)
  begin
    if (in_reset)
    begin
      addr_q <= '0;
    end
    else if (store_d)
    begin
      addr_q <= bus.register_select_lines;
    end
  end

  always_ff @(posedge clk)
  begin
    if (in_reset)
    begin
      data_q <= '0;
    end
    else if (store_d)
    begin
      data_q <= bus_in;
    end
  end

  // Read data lags the register select lines by a cycle; the strobe must stand two
  always_ff @(posedge clk)
  begin
    if (in_reset)
    begin
      rd_q <= '0;
    end
    else
    begin
      rd_q <= rd_sel;
    end
  end

  // One write strobe per implemented register
  genvar g;
  generate
    for (g = 0; g < NREGS; g++)
    begin : g_reg
      assign wr_hit[g] = store_end & wr_addr_ok & (int'(addr_q) == g);
      always_ff @(posedge clk)
      begin
        if (in_reset)
        begin
          regs_q[g] <= `FPHP_REG_RESET;
        end
        else if (wr_hit[g])
        begin
          regs_q[g] <= data_q;
        end
      end
    end
  endgenerate

  // Data bus driven only while selected and read-qualified
  assign bus.dev_data_o  = rd_q;
  assign bus.dev_data_oe = drive_read;
  // Open drain: only pulls low, the released level comes from the pull-up
  assign bus.irq_pull_oe = irq_any;

  assign core_reset = in_reset;
  assign wr_data    = data_q;
  assign wr_addr    = addr_q;
  assign wr_pulse   = wr_pulse_q;
endmodule

`default_nettype wire

// file: design/fphp_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "fphp_params.svh"

module fphp_host #(
  parameter int RESET_CYCLES = `FPHP_RESET_CYCLES,
  parameter int HOLD         = `FPHP_STROBE_HOLD
)
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  fphp_bus_if.host                  bus,
  input  wire logic                 style_pair,
  input  wire logic                 req_valid,
  input  wire logic                 req_write,
  input  wire fphp_pkg::fphp_addr_t req_addr,
  input  wire fphp_pkg::fphp_data_t req_wdata,
  output logic                      req_ready,
  output fphp_pkg::fphp_data_t      rsp_rdata,
  output logic                      rsp_valid,
  output logic                      irq_pending
);
  import fphp_pkg::*;

  fphp_hstate_t st_q;
  logic [15:0]  rcnt_q;
  logic [7:0]   hcnt_q;
  logic         wr_q;
  fphp_addr_t   addr_q;
  fphp_data_t   wdata_q;
  fphp_data_t   rdata_q;
  logic         rvalid_q;

  wire in_rst   = rcnt_q != 16'(RESET_CYCLES);
  wire strobing = st_q == FPHP_PULSE;

  always_ff @(posedge clk)
  begin
    if (rst)
      rcnt_q <= '0;
    else if (in_rst)
      rcnt_q <= rcnt_q + 16'h0001;
  end

  always_ff @(posedge clk)
  begin
    if (rst || in_rst)
    begin
      st_q     <= FPHP_IDLE;
      hcnt_q   <= '0;
      wr_q     <= 1'b0;
      addr_q   <= '0;
      wdata_q  <= '0;
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= 1'b0;
      case (st_q)
        FPHP_IDLE:
          if (req_valid)
          begin
            st_q    <= FPHP_SETUP;
            wr_q    <= req_write;
            addr_q  <= req_addr;
            wdata_q <= req_wdata;
          end
        FPHP_SETUP:
        begin
          st_q   <= FPHP_PULSE;
          hcnt_q <= '0;
        end
        FPHP_PULSE:
        begin
          hcnt_q <= hcnt_q + 8'h01;
          if (int'(hcnt_q) == HOLD - 1)
          begin
            st_q <= FPHP_DONE;
            if (!wr_q)
            begin
              rdata_q  <= bus.data_bus;
              rvalid_q <= 1'b1;
            end
          end
        end
        FPHP_DONE:
          st_q <= FPHP_IDLE;
        default:
          st_q <= FPHP_IDLE;
      endcase
    end
  end

  assign bus.reset_n               = ~in_rst;
  assign bus.bus_style_select      = style_pair;
  assign bus.select_n              = ~(st_q != FPHP_IDLE);
  assign bus.register_select_lines = addr_q;
  assign bus.data_strobe_n         = style_pair ? ~(strobing & ~wr_q) : ~strobing;
  assign bus.dir_store_n           = style_pair ? ~(strobing & wr_q) : ~wr_q;
  assign bus.host_data_o           = wdata_q;
  assign bus.host_data_oe          = wr_q & (st_q != FPHP_IDLE);
  assign req_ready                 = ~in_rst & (st_q == FPHP_IDLE);
  assign rsp_rdata                 = rdata_q;
  assign rsp_valid                 = rvalid_q;
  assign irq_pending               = ~bus.irq_n;
endmodule

`default_nettype wire

// file: verification/fphp_bus_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fphp_bus_chk
  import fphp_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       bus_style_select,
  input wire logic       data_strobe_n,
  input wire logic       dir_store_n,
  input wire logic       select_n,
  input wire logic       reset_n,
  input wire fphp_addr_t register_select_lines,
  input wire logic       host_data_oe,
  input wire logic       dev_data_oe
);
  localparam int RST_MIN = 250;
  logic [8:0] low_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
    if (rst || reset_n)
      low_q <= 9'h000;
    else if (low_q != 9'h1FF)
      low_q <= low_q + 9'h001;
  sequence s_rd;
    !select_n && !data_strobe_n && (bus_style_select || dir_store_n);
  endsequence
  chk_float_idle: assert property (select_n |-> !dev_data_oe)
    else $error("data driven while unselected");
  chk_read_qual: assert property (dev_data_oe |-> s_rd)
    else $error("data driven outside read");
  chk_pair_store: assert property (bus_style_select && !dir_store_n |-> !dev_data_oe)
    else $error("data driven during store");
  chk_read_drive: assert property (s_rd ##1 s_rd |-> dev_data_oe)
    else $error("read not driven");
  chk_no_fight: assert property (host_data_oe |-> !dev_data_oe)
    else $error("both ends drive data");
  chk_strobe_sel: assert property (!data_strobe_n |-> !select_n)
    else $error("strobe without select");
  chk_addr_hold: assert property (!select_n && $past(!select_n) |-> $stable(register_select_lines))
    else $error("address moved in access");
  chk_reset_long: assert property ($rose(reset_n) |-> low_q >= RST_MIN)
    else $error("device reset too short");
endmodule
`default_nettype wire

// file: verification/framer_parallel_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module framer_parallel_host_port_tb;
  import fphp_pkg::*;
  logic        clk, rst, style_pair, req_valid, req_write, req_ready;
  logic        rsp_valid, irq_pending, wr_pulse, core_reset;
  logic [31:0] irq_src;
  fphp_addr_t  req_addr, wr_addr;
  fphp_data_t  req_wdata, rsp_rdata, wr_data, got;
  int          n_mismatch, total_checks, cyc;
  fphp_addr_t  adr [3] = '{5'h00, 5'h1F, 5'h0A};
  fphp_data_t  dat [3] = '{8'hA5, 8'h5A, 8'h01};
  fphp_bus_if  bus ();
  fphp_host fphp_host_i (.clk(clk), .rst(rst), .bus(bus), .style_pair(style_pair),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .req_ready(req_ready), .rsp_rdata(rsp_rdata),
    .rsp_valid(rsp_valid), .irq_pending(irq_pending));
  fphp_device fphp_device_i (.clk(clk), .rst(rst), .bus(bus), .irq_src(irq_src),
    .core_reset(core_reset), .wr_data(wr_data), .wr_addr(wr_addr), .wr_pulse(wr_pulse));
  fphp_bus_chk fphp_bus_chk_i (.clk(clk), .rst(rst),
    .bus_style_select(bus.bus_style_select), .data_strobe_n(bus.data_strobe_n),
    .dir_store_n(bus.dir_store_n), .select_n(bus.select_n), .reset_n(bus.reset_n),
    .register_select_lines(bus.register_select_lines),
    .host_data_oe(bus.host_data_oe), .dev_data_oe(bus.dev_data_oe));
  task automatic chk(input string nm, input fphp_data_t exp, input fphp_data_t act);
    total_checks++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, act);
    end
  endtask
  task automatic acc(input logic w, input fphp_addr_t a, input fphp_data_t d);
    int n;
    @(negedge clk);
    for (n = 0; n < 400 && req_ready !== 1'b1; n++)
      @(negedge clk);
    chk("req_ready", 8'h01, {7'h00, req_ready});
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    for (n = 0; n < 20 && (w ? wr_pulse : rsp_valid) !== 1'b1; n++)
      @(negedge clk);
    chk("done", 8'h01, {7'h00, w ? wr_pulse : rsp_valid});
    got = w ? wr_data : rsp_rdata;
    if (w)
      chk("wr_addr", {3'h0, a}, {3'h0, wr_addr});
  endtask
  task automatic t_style(input logic p);
    @(posedge clk);
    style_pair <= p;
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, adr[i], dat[i] ^ {8{p}});
      chk("wr_data", dat[i] ^ {8{p}}, got);
    end
    chk("style", {7'h00, p}, {7'h00, bus.bus_style_select});
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, adr[i], 8'h00);
      chk("rd_data", dat[i] ^ {8{p}}, got);
    end
    $display("style %0d test done", p);
  endtask
  task automatic t_reset();
    @(negedge clk);
    chk("core_reset", 8'h01, {7'h00, core_reset});
    chk("ready_rst", 8'h00, {7'h00, req_ready});
    $display("reset test done");
  endtask
  task automatic t_irq();
    @(posedge clk);
    irq_src <= 32'h8000_0000;
    repeat (3) @(negedge clk);
    chk("irq_on", 8'h01, {7'h00, irq_pending});
    chk("idle_bus", 8'hFF, bus.data_bus);
    chk("core_run", 8'h00, {7'h00, core_reset});
    @(posedge clk);
    irq_src <= 32'h0000_0000;
    repeat (3) @(negedge clk);
    chk("irq_off", 8'h00, {7'h00, irq_pending});
    $display("irq test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      final_report();
    end
  end
  initial
  begin
    {rst, style_pair, req_valid, req_write} = 4'h8;
    {req_addr, req_wdata, irq_src} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_style(1'b0);
    t_style(1'b1);
    t_irq();
    final_report();
  end
endmodule
`default_nettype wire
